/* rtl/schrc_pkg.sv */
package schrc_pkg;

  // register offsets; read-only and write-only pairs share a slot
  localparam logic [3:0] ADDR_COUNT_LO = 4'h0;
  localparam logic [3:0] ADDR_COUNT_HI = 4'h1;
  localparam logic [3:0] ADDR_FIFO = 4'h2;
  localparam logic [3:0] ADDR_COMMAND = 4'h3;
  localparam logic [3:0] ADDR_PHASE_TARGET = 4'h4;
  localparam logic [3:0] ADDR_CAUSE_TIMEOUT = 4'h5;
  localparam logic [3:0] ADDR_STATE_PERIOD = 4'h6;
  localparam logic [3:0] ADDR_LEVEL_OFFSET = 4'h7;
  localparam logic [3:0] ADDR_CONFIG_ONE = 4'h8;
  localparam logic [3:0] ADDR_CLOCK_CONV = 4'h9;
  localparam logic [3:0] ADDR_FORCED_TEST = 4'hA;
  localparam logic [3:0] ADDR_CONFIG_TWO = 4'hB;
  localparam logic [3:0] ADDR_CONFIG_THREE = 4'hC;
  localparam logic [3:0] ADDR_BYTE_ALIGN = 4'hF;

  // command fields and the commands that skip the queue
  localparam int CMD_DMA_BIT = 7;
  localparam logic [6:0] CMD_RESET_DEVICE = 7'h02;
  localparam logic [6:0] CMD_RESET_BUS = 7'h03;
  localparam logic [6:0] CMD_DMA_STOP = 7'h04;

  // reset values
  localparam logic [7:0] FIFO_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'h00;

  // fifo shape and phase-flag field position
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_WIDTH = 9;
  localparam int PHASE_CTZ_BIT = 4;

  // bus reset timing: a 1 us tick from the 20 MHz clock
  localparam int CLK_HZ = 20_000_000;
  localparam int TICK_US = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
  localparam int BUS_RESET_MIN_MS = 25;
  localparam int BUS_RESET_MAX_MS = 40;
  localparam int BUS_RESET_TICKS = BUS_RESET_MIN_MS * 1000 / TICK_US;

  // write-side configuration handed to the sequencer
  typedef struct packed {
    logic [7:0] target_id_select;
    logic [7:0] selection_timeout;
    logic [7:0] sync_period;
    logic [7:0] sync_offset;
    logic [7:0] config_one;
    logic [7:0] clock_conversion;
    logic [7:0] forced_test;
    logic [7:0] config_two;
    logic [7:0] config_three;
    logic [7:0] byte_alignment;
  } schrc_cfg_type;

  // role and phase as the sequencer reports them
  typedef struct packed {
    logic target;
    logic initiator;
    logic data_phase;
    logic data_in;
    logic sync_mode;
    logic word_mode;
  } schrc_role_type;

  typedef struct packed {
    logic dma;
    logic [6:0] code;
  } schrc_cmd_type;

  typedef enum logic [1:0] {
    BRST_IDLE = 2'b01,
    BRST_DRIVE = 2'b10
  } schrc_brst_state_type;

endpackage

/* rtl/schrc_fifo.sv */
`timescale 1ns/1ps
module schrc_fifo
  import schrc_pkg::*;
#(
  parameter int WIDTH = FIFO_WIDTH,
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_clear,
  // fill side
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  // drain side
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data,
  // occupancy
  output logic [$clog2(DEPTH):0] o_count
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW-1:0] rd_next;
  logic push;
  logic pop;

  assign o_ready = (o_count != DEPTH[AW:0]);
  assign o_valid = (o_count != '0);
  assign push = i_valid & o_ready;
  assign pop = o_valid & i_ready;
  assign rd_next = rd_ptr + 1'b1;

  // storage has no reset; the head register masks stale words
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_data;
    end
  end

  // pointers and count
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      o_count <= '0;
    end else if (i_clear) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      o_count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_next;
      end
      o_count <= o_count + push - pop;
    end
  end

  // registered head word, shown ahead of the pop
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_data <= '0;
    end else if (i_clear) begin
      o_data <= '0;
    end else if (push && (o_count == '0 || (pop && o_count == 1))) begin
      o_data <= i_data;
    end else if (pop && o_count > 1) begin
      o_data <= mem[rd_next];
    end
  end

endmodule

/* rtl/schrc_top.sv */
`timescale 1ns/1ps
module schrc_top
  import schrc_pkg::*;
#(
  parameter int P_BUS_RESET_TICKS = BUS_RESET_TICKS,
  parameter int P_FIFO_DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // host register port
  input wire logic i_cs_n,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_data,
  output logic [7:0] o_data,
  // dma port
  input wire logic i_dma_grant_n,
  input wire logic i_dma_fetch_strobe_n,
  input wire logic i_dma_store_strobe_n,
  // sequencer side
  input wire schrc_role_type i_role,
  input wire logic i_request_want,
  input wire logic i_acknowledge_want,
  input wire logic i_selection_start,
  input wire logic i_cmd_done,
  input wire logic [7:0] i_phase_flags,
  input wire logic [7:0] i_interrupt_cause,
  input wire logic [7:0] i_sequence_state,
  output logic o_cmd_start,
  output schrc_cmd_type o_cmd,
  output logic o_cmd_overrun,
  output logic o_dma_stop,
  output logic o_soft_reset,
  output logic o_count_zero_flag,
  output schrc_cfg_type o_cfg,
  // scsi byte stream through the fifo
  input wire logic i_link_valid,
  output logic o_link_ready,
  input wire logic [8:0] i_link_data,
  output logic o_link_valid,
  input wire logic i_link_ready,
  output logic [8:0] o_link_data,
  // scsi control pins
  input wire logic i_differential_select_n,
  output logic o_bus_reset_drive,
  output logic o_bus_reset_drive_oe_n,
  output logic o_request_drive,
  output logic o_request_drive_oe_n,
  output logic o_acknowledge_drive,
  output logic o_acknowledge_drive_oe_n,
  output logic o_initiator_side_enable,
  output logic o_target_side_enable
);
  localparam int CW = $clog2(P_FIFO_DEPTH);

  logic rst_q1;
  logic rst_n;
  logic rd_act, rd_act_q, wr_act, wr_act_q;
  logic dma_rd, dma_wr, cs_rd, cs_wr;
  logic rd_start, wr_start, reg_wr, fifo_wr, fifo_rd;
  logic [15:0] count_load_bits;
  logic [16:0] count_now_bits;
  schrc_cmd_type cmd_exec, cmd_pend, wr_cmd;
  logic cmd_busy, pend_valid, cmd_imm;
  logic grant_q, req_q, ack_q, grant_edge, req_edge, ack_edge;
  logic dec_step;
  logic [16:0] dec_amount;
  logic fifo_clear, f_in_valid, f_in_ready, f_out_valid, f_out_ready;
  logic [8:0] f_in_data, f_out_data;
  logic [CW:0] f_count;
  logic [7:0] rd_mux;
  logic brst_start;
  schrc_brst_state_type brst_state;
  logic [4:0] tick_cnt;
  logic tick;
  logic [15:0] brst_ticks;
  logic brst_active;

  // reset release through two flops
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  // access decode; grant accesses ignore the address
  assign cs_rd = !i_cs_n & !i_rd_n;
  assign cs_wr = !i_cs_n & !i_wr_n;
  assign dma_rd = !i_dma_grant_n & (!i_dma_fetch_strobe_n | !i_rd_n);
  assign dma_wr = !i_dma_grant_n & (!i_dma_store_strobe_n | !i_wr_n);
  assign rd_act = cs_rd | dma_rd;
  assign wr_act = cs_wr | dma_wr;
  assign rd_start = rd_act & !rd_act_q;
  assign wr_start = wr_act & !wr_act_q;
  // a grant access only ever touches the fifo
  assign reg_wr = wr_start & !dma_wr;
  assign fifo_wr = wr_start & (dma_wr | i_addr == ADDR_FIFO);
  assign fifo_rd = rd_start & (dma_rd | i_addr == ADDR_FIFO);
  assign wr_cmd = schrc_cmd_type'(i_data);
  assign cmd_imm = reg_wr && i_addr == ADDR_COMMAND &&
                   (wr_cmd.code == CMD_RESET_DEVICE ||
                    wr_cmd.code == CMD_RESET_BUS ||
                    wr_cmd.code == CMD_DMA_STOP);

  // strobe edge history, one access per strobe assertion
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_act_q <= 1'b0;
      wr_act_q <= 1'b0;
    end else begin
      rd_act_q <= rd_act;
      wr_act_q <= wr_act;
    end
  end

  // write-only and read/write configuration
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_cfg <= '0;
    end else if (reg_wr) begin
      case (i_addr)
        ADDR_PHASE_TARGET: o_cfg.target_id_select <= i_data;
        ADDR_CAUSE_TIMEOUT: o_cfg.selection_timeout <= i_data;
        ADDR_STATE_PERIOD: o_cfg.sync_period <= i_data;
        ADDR_LEVEL_OFFSET: o_cfg.sync_offset <= i_data;
        ADDR_CONFIG_ONE: o_cfg.config_one <= i_data;
        ADDR_CLOCK_CONV: o_cfg.clock_conversion <= i_data;
        ADDR_FORCED_TEST: o_cfg.forced_test <= i_data;
        ADDR_CONFIG_TWO: o_cfg.config_two <= i_data;
        ADDR_CONFIG_THREE: o_cfg.config_three <= i_data;
        ADDR_BYTE_ALIGN: o_cfg.byte_alignment <= i_data;
        default: o_cfg <= o_cfg;
      endcase
    end
  end

  // start count has no reset at all: it must survive both resets
  always_ff @(posedge i_clk) begin
    if (reg_wr && i_addr == ADDR_COUNT_LO) begin
      count_load_bits[7:0] <= i_data;
    end
    if (reg_wr && i_addr == ADDR_COUNT_HI) begin
      count_load_bits[15:8] <= i_data;
    end
  end

  // two-deep command queue; immediate commands never enter it
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_exec <= CMD_RESET;
      cmd_pend <= CMD_RESET;
      cmd_busy <= 1'b0;
      pend_valid <= 1'b0;
      o_cmd_start <= 1'b0;
      o_cmd_overrun <= 1'b0;
    end else begin
      o_cmd_start <= 1'b0;
      o_cmd_overrun <= 1'b0;
      if (o_soft_reset) begin
        cmd_busy <= 1'b0;
        pend_valid <= 1'b0;
      end else if (reg_wr && i_addr == ADDR_COMMAND && !cmd_imm) begin
        if (!cmd_busy || (i_cmd_done && !pend_valid)) begin
          cmd_exec <= wr_cmd;
          cmd_busy <= 1'b1;
          o_cmd_start <= 1'b1;
        end else if (i_cmd_done) begin
          cmd_exec <= cmd_pend;
          cmd_pend <= wr_cmd;
          o_cmd_start <= 1'b1;
        end else begin
          cmd_pend <= wr_cmd;
          pend_valid <= 1'b1;
          o_cmd_overrun <= pend_valid;
        end
      end else if (i_cmd_done && cmd_busy) begin
        if (pend_valid) begin
          cmd_exec <= cmd_pend;
          pend_valid <= 1'b0;
          o_cmd_start <= 1'b1;
        end else begin
          cmd_busy <= 1'b0;
        end
      end
    end
  end
  assign o_cmd = cmd_exec;

  // immediate commands act on the write itself
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_dma_stop <= 1'b0;
      o_soft_reset <= 1'b0;
      brst_start <= 1'b0;
    end else begin
      o_dma_stop <= cmd_imm && wr_cmd.code == CMD_DMA_STOP;
      o_soft_reset <= cmd_imm && wr_cmd.code == CMD_RESET_DEVICE;
      brst_start <= cmd_imm && wr_cmd.code == CMD_RESET_BUS;
    end
  end

  // decrement sources picked by role and phase
  assign grant_edge = !i_dma_grant_n & grant_q;
  assign req_edge = !o_request_drive_oe_n & !req_q;
  assign ack_edge = !o_acknowledge_drive_oe_n & !ack_q;
  always_comb begin
    dec_step = 1'b0;
    if (i_role.data_phase) begin
      if (i_role.target) begin
        dec_step = i_role.data_in ? grant_edge : req_edge;
      end else if (i_role.initiator) begin
        if (i_role.data_in) begin
          dec_step = i_role.sync_mode ? grant_edge : ack_edge;
        end else begin
          dec_step = grant_edge;
        end
      end
    end
  end
  // a word moves two bytes; never count past zero
  assign dec_amount = i_role.word_mode ? 17'h00002 : 17'h00001;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      grant_q <= 1'b1;
      req_q <= 1'b0;
      ack_q <= 1'b0;
    end else begin
      grant_q <= i_dma_grant_n;
      req_q <= !o_request_drive_oe_n;
      ack_q <= !o_acknowledge_drive_oe_n;
    end
  end

  // current count is 17 bits so that a zero load means 65536
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_now_bits <= 17'h00000;
    end else if (o_cmd_start && cmd_exec.dma) begin
      count_now_bits <= {count_load_bits == 16'h0000,
                         count_load_bits};
    end else if (dec_step && count_now_bits != 17'h00000) begin
      if (count_now_bits < dec_amount) begin
        count_now_bits <= 17'h00000;
      end else begin
        count_now_bits <= count_now_bits - dec_amount;
      end
    end
  end

  // zero flag: reaching zero wins over a load in the same cycle
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_count_zero_flag <= 1'b0;
    end else if (o_soft_reset) begin
      o_count_zero_flag <= 1'b0;
    end else if (dec_step && count_now_bits != 17'h00000 &&
                 count_now_bits <= dec_amount) begin
      o_count_zero_flag <= 1'b1;
    end else if (o_cmd_start && cmd_exec.dma) begin
      o_count_zero_flag <= 1'b0;
    end
  end

  // shared fifo: host side has priority on both ends
  assign fifo_clear = o_soft_reset | i_selection_start;
  assign f_in_valid = fifo_wr | i_link_valid;
  assign f_in_data = fifo_wr ? {~^i_data, i_data} : i_link_data;
  assign o_link_ready = f_in_ready & !fifo_wr;
  assign f_out_ready = fifo_rd | i_link_ready;
  assign o_link_valid = f_out_valid & !fifo_rd;
  assign o_link_data = f_out_data;

  schrc_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(P_FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_clear(fifo_clear),
    .i_valid(f_in_valid),
    .o_ready(f_in_ready),
    .i_data(f_in_data),
    .o_valid(f_out_valid),
    .i_ready(f_out_ready),
    .o_data(f_out_data),
    .o_count(f_count)
  );

  // read mux; unmapped offsets read as zero
  always_comb begin
    case (i_addr)
      ADDR_COUNT_LO: rd_mux = count_now_bits[7:0];
      ADDR_COUNT_HI: rd_mux = count_now_bits[15:8];
      ADDR_FIFO: rd_mux = f_out_valid ? f_out_data[7:0] : FIFO_RESET;
      ADDR_COMMAND: rd_mux = cmd_exec;
      ADDR_PHASE_TARGET: begin
        rd_mux = i_phase_flags;
        rd_mux[PHASE_CTZ_BIT] = o_count_zero_flag;
      end
      ADDR_CAUSE_TIMEOUT: rd_mux = i_interrupt_cause;
      ADDR_STATE_PERIOD: rd_mux = i_sequence_state;
      ADDR_LEVEL_OFFSET: rd_mux = {i_sequence_state[7:5],
                                   5'(f_count)};
      ADDR_CONFIG_ONE: rd_mux = o_cfg.config_one;
      ADDR_CONFIG_TWO: rd_mux = o_cfg.config_two;
      ADDR_CONFIG_THREE: rd_mux = o_cfg.config_three;
      default: rd_mux = DATA_RESET;
    endcase
    if (dma_rd) begin
      rd_mux = f_out_valid ? f_out_data[7:0] : FIFO_RESET;
    end
  end

  // read data is caught once per strobe and held
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_data <= DATA_RESET;
    end else if (rd_start) begin
      o_data <= rd_mux;
    end
  end

  // 1 us tick, only running while the bus reset is driven
  assign tick = brst_active && tick_cnt == 5'(TICK_CYCLES - 1);
  assign brst_active = brst_state == BRST_DRIVE;
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= 5'h00;
    end else if (!brst_active || tick) begin
      tick_cnt <= 5'h00;
    end else begin
      tick_cnt <= tick_cnt + 5'h01;
    end
  end

  // bus reset length counted in ticks; 25 ms at 20 MHz
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      brst_state <= BRST_IDLE;
      brst_ticks <= 16'h0000;
    end else begin
      case (brst_state)
        BRST_IDLE: begin
          brst_ticks <= 16'h0000;
          if (brst_start) begin
            brst_state <= BRST_DRIVE;
          end
        end
        BRST_DRIVE: begin
          if (tick) begin
            brst_ticks <= brst_ticks + 16'h0001;
            if (brst_ticks == 16'(P_BUS_RESET_TICKS - 1)) begin
              brst_state <= BRST_IDLE;
            end
          end
        end
        default: brst_state <= BRST_IDLE;
      endcase
    end
  end

  // pin drives; differential mode turns reset into a push-pull
  // direction control, single ended pulls the line low
  assign o_bus_reset_drive = !i_differential_select_n & brst_active;
  assign o_bus_reset_drive_oe_n = i_differential_select_n ?
                                  !brst_active : 1'b0;
  assign o_request_drive = 1'b0;
  assign o_request_drive_oe_n = !(i_request_want & i_role.target);
  assign o_acknowledge_drive = 1'b0;
  assign o_acknowledge_drive_oe_n =
    !(i_acknowledge_want & i_role.initiator);
  assign o_initiator_side_enable = i_role.initiator;
  assign o_target_side_enable = i_role.target;

  // helper: cycles the reset has been driven
  logic [23:0] a_brst_cycles;
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      a_brst_cycles <= '0;
    end else begin
      a_brst_cycles <= brst_active ? a_brst_cycles + 1'b1 : '0;
    end
  end

  default clocking a_clk @(posedge i_clk); endclocking
  default disable iff (!rst_n);

  a_bus_reset_len: assert property (
    $fell(brst_active) |->
      $past(a_brst_cycles) == 24'(P_BUS_RESET_TICKS * TICK_CYCLES - 1))
    else $error("bus reset length wrong");
  a_bus_reset_start: assert property (
    brst_start && !brst_active |=> brst_active[*8])
    else $error("bus reset not held");
  a_request_role: assert property (
    !o_request_drive_oe_n |-> i_role.target)
    else $error("request driven outside target role");
  a_ack_role: assert property (
    !o_acknowledge_drive_oe_n |-> o_initiator_side_enable)
    else $error("acknowledge driven outside initiator role");
  a_grant_only_fifo: assert property (
    dma_wr && wr_start && !cs_wr |=> $stable(o_cfg))
    else $error("grant write reached a register");
  a_count_load: assert property (
    o_cmd_start && cmd_exec.dma |=>
      count_now_bits == {$past(count_load_bits) == 16'h0000,
                         $past(count_load_bits)})
    else $error("counter not loaded from start count");
  a_count_step: assert property (
    dec_step && !(o_cmd_start && cmd_exec.dma) &&
    count_now_bits > 17'h00002 |=>
      count_now_bits == $past(count_now_bits) - $past(dec_amount))
    else $error("counter step wrong");
  a_zero_flag: assert property (
    $rose(o_count_zero_flag) && !$past(o_cmd_start) |->
      count_now_bits == 17'h00000)
    else $error("zero flag without zero count");
  a_fifo_cleared: assert property (
    fifo_clear |=> f_count == '0 && !f_out_valid)
    else $error("fifo not cleared");
  a_cmd_queue: assert property (
    reg_wr && i_addr == ADDR_COMMAND && !cmd_imm && cmd_busy &&
    !i_cmd_done && !o_soft_reset |=> pend_valid ##0 cmd_busy)
    else $error("second command not queued");
  a_stop_now: assert property (
    cmd_imm && wr_cmd.code == CMD_DMA_STOP |=>
      o_dma_stop && $stable(cmd_exec))
    else $error("dma stop not immediate");

  c_bus_reset: cover property (brst_start);
  c_count_zero: cover property ($rose(o_count_zero_flag));
  c_queue_two: cover property (pend_valid && cmd_busy);
  c_fifo_full: cover property (!f_in_ready);

endmodule

/* dv/schrc_link_model.sv */
`timescale 1ns/1ps
module schrc_link_model (
  // clock, reset and enable
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_run,
  // fifo drain side
  input wire logic i_valid,
  input wire logic [8:0] i_data,
  output logic o_ready,
  // fifo fill side, kept idle
  output logic o_valid,
  output logic [8:0] o_data,
  // drain record
  output int o_popped,
  output logic [8:0] o_last
);
  assign o_valid = 1'b0;
  // stall every other cycle; idle data toggles so stale bytes never match
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ready <= 1'b0;
      o_popped <= 0;
      o_last <= 9'h000;
      o_data <= 9'h000;
    end else begin
      o_ready <= i_run & !o_ready;
      o_data <= ~o_data;
      if (i_valid & o_ready) begin
        o_popped <= o_popped + 1;
        o_last <= i_data;
      end
    end
  end
endmodule

/* dv/scsi_ctrl_host_regs_counter_test.sv */
`timescale 1ns/1ps
module scsi_ctrl_host_regs_counter_test import schrc_pkg::*; ();
  logic clk = 0, nrst = 0, cs_n = 1, rd_n = 1, wr_n = 1, gnt_n = 1;
  logic ss_n = 1, done = 0, sel = 0, run = 0, rq = 0, ak = 0;
  logic fs_n = 1, dif_n = 1, rsd, cst, ovr, srst;
  logic [7:0] ph = 8'hA5;
  logic [3:0] addr = 4'h0;
  logic [7:0] din = 8'h00, dout;
  schrc_role_type role = '0;
  schrc_cfg_type cfg;
  schrc_cmd_type cmd;
  logic lv, lr, pv, pr, stop, flag, rst_oe_n, rq_oe_n, ak_oe_n, ise, tse;
  logic [8:0] ld, pd, last;
  int num_errors = 0, comparisons = 0, bus_reset_drive = 0, stops = 0, popped;
  int srsts = 0, ovrs = 0, starts = 0;
  schrc_top #(.P_BUS_RESET_TICKS(4)) dut (.i_clk(clk), .i_nrst(nrst),
    .i_cs_n(cs_n), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_addr(addr),
    .i_data(din), .o_data(dout), .i_dma_grant_n(gnt_n),
    .i_dma_fetch_strobe_n(fs_n), .i_dma_store_strobe_n(ss_n),
    .i_role(role), .i_request_want(rq), .i_acknowledge_want(ak),
    .i_selection_start(sel), .i_cmd_done(done), .i_phase_flags(ph),
    .i_interrupt_cause(8'h00), .i_sequence_state(8'h00),
    .o_cmd_start(cst), .o_cmd(cmd), .o_cmd_overrun(ovr),
    .o_dma_stop(stop),
    .o_soft_reset(srst), .o_count_zero_flag(flag), .o_cfg(cfg),
    .i_link_valid(lv), .o_link_ready(lr), .i_link_data(ld),
    .o_link_valid(pv), .i_link_ready(pr), .o_link_data(pd),
    .i_differential_select_n(dif_n), .o_bus_reset_drive(rsd),
    .o_bus_reset_drive_oe_n(rst_oe_n), .o_request_drive(),
    .o_request_drive_oe_n(rq_oe_n), .o_acknowledge_drive(),
    .o_acknowledge_drive_oe_n(ak_oe_n),
    .o_initiator_side_enable(ise), .o_target_side_enable(tse));
  schrc_link_model far (.i_clk(clk), .i_rst_n(nrst), .i_run(run),
    .i_valid(pv), .i_data(pd), .o_ready(pr), .o_valid(lv),
    .o_data(ld), .o_popped(popped), .o_last(last));
  always #25 clk = ~clk;
  // bus reset length and stop pulses tallied as they happen
  always @(posedge clk) begin
    if (rst_oe_n === 1'b0) bus_reset_drive++;
    if (stop === 1'b1) stops++;
    if (srst === 1'b1) srsts++;
    if (ovr === 1'b1) ovrs++;
    if (cst === 1'b1) starts++;
  end
  task automatic conclude();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // strobe held three edges, then a clear edge before the next access
  task automatic acc(input logic w, input logic [3:0] a, logic [7:0] d);
    @(posedge clk);
    cs_n <= 1'b0;
    rd_n <= w;
    wr_n <= !w;
    addr <= a;
    din <= d;
    repeat (3) @(posedge clk);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    @(posedge clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    #1 chk(dout, e);
  endtask
  // grant access with a misleading address; one grant pulse
  task automatic dw(input logic [7:0] d, input logic strobe);
    @(posedge clk);
    gnt_n <= 1'b0;
    ss_n <= !strobe;
    addr <= 4'h8;
    din <= d;
    repeat (strobe ? 3 : 1) @(posedge clk);
    gnt_n <= 1'b1;
    ss_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
  task automatic pulse(input logic s);
    @(posedge clk);
    sel <= s;
    done <= !s;
    @(posedge clk);
    sel <= 1'b0;
    done <= 1'b0;
  endtask
  task automatic reset();
    nrst <= 1'b0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  initial begin
    reset();
    wr(4'h8, 8'h3C);
    chk(cfg.config_one, 8'h3C);
    rd(4'h8, 8'h3C);
    rd(4'hD, 8'h00);
    for (int i = 1; i < 18; i++) wr(4'h2, 8'(i));
    chk(lr, 1'b0);
    rd(4'h7, 8'h10);
    rd(4'h2, 8'h01);
    run <= 1'b1;
    for (int i = 0; i < 400 && popped < 15; i++) @(posedge clk);
    if (popped != 15) begin
      num_errors++;
      $display("BAD %0t fifo drain timed out", $time);
      conclude();
    end
    chk(last[7:0], 8'h10);
    run <= 1'b0;
    dw(8'h5A, 1'b1);
    rd(4'h7, 8'h01);
    rd(4'h8, 8'h3C);
    // dma fetch strobe pops the fifo, address ignored
    @(posedge clk);
    gnt_n <= 1'b0;
    fs_n <= 1'b0;
    repeat (3) @(posedge clk);
    gnt_n <= 1'b1;
    fs_n <= 1'b1;
    @(posedge clk);
    chk(dout, 8'h5A);
    dw(8'h66, 1'b1);
    pulse(1'b1);
    rd(4'h7, 8'h00);
    chk(lr, 1'b1);
    // each role in turn with both drive requests held
    for (int t = 0; t < 2; t++) begin
      role.target <= t[0];
      role.initiator <= !t[0];
      rq <= 1'b1;
      ak <= 1'b1;
      repeat (2) @(posedge clk);
      chk(tse, t[0]);
      chk(ise, !t[0]);
      chk(rq_oe_n, !t[0]);
      chk(ak_oe_n, t[0]);
    end
    rq <= 1'b0;
    ak <= 1'b0;
    role <= '{target: 0, initiator: 1, data_phase: 1, default: 0};
    wr(4'h0, 8'h00);
    wr(4'h1, 8'h00);
    wr(4'h3, 8'h90);
    dw(8'h00, 1'b0);
    rd(4'h1, 8'hFF);
    rd(4'h0, 8'hFF);
    pulse(1'b0);
    wr(4'h0, 8'h07);
    wr(4'h3, 8'h90);
    // target data-out: one request assertion moves a word
    role <= '{target: 1, data_phase: 1, word_mode: 1, default: 0};
    rq <= 1'b1;
    repeat (2) @(posedge clk);
    rq <= 1'b0;
    role <= '{initiator: 1, data_phase: 1, word_mode: 1, default: 0};
    dw(8'h00, 1'b0);
    dw(8'h00, 1'b0);
    rd(4'h0, 8'h01);
    role.word_mode <= 1'b0;
    dw(8'h00, 1'b0);
    chk(flag, 1'b1);
    rd(4'h4, 8'hB5);
    pulse(1'b0);
    wr(4'h3, 8'h11);
    chk(cmd, 8'h11);
    wr(4'h3, 8'h12);
    chk(cmd, 8'h11);
    wr(4'h3, 8'h13);
    chk(ovrs, 1);
    wr(4'h3, 8'h04);
    chk(stops, 1);
    pulse(1'b0);
    repeat (2) @(posedge clk);
    chk(cmd, 8'h13);
    chk(starts, 4);
    rd(4'h3, 8'h13);
    wr(4'h3, 8'h03);
    repeat (120) @(posedge clk);
    chk(bus_reset_drive, 80);
    chk(rsd, 1'b0);
    // differential: the reset pin becomes a push-pull direction
    dif_n <= 1'b0;
    wr(4'h3, 8'h03);
    repeat (10) @(posedge clk);
    chk(rsd, 1'b1);
    chk(rst_oe_n, 1'b0);
    repeat (80) @(posedge clk);
    chk(rsd, 1'b0);
    dif_n <= 1'b1;
    wr(4'h3, 8'h02);
    chk(flag, 1'b0);
    chk(srsts, 1);
    reset();
    wr(4'h3, 8'h90);
    rd(4'h0, 8'h07);
    conclude();
  end
endmodule
